/* File: design/psc_top.sv */
/*
  one pwm slice with two parameter outputs: timer, alignment and compare
  modes, parameter flags, control and shared mirror registers.
  assumes pwm_tick_i is a one-cycle strobe from the prescaler on clock_i,
  period_value_i comes from the period register on clock_i, and
  ext_reset_i is an asynchronous pin.
*/
`include "psc_defines.svh"
`default_nettype none

// Overview of operation
// [R1] second flag: match, output change, pulse start or end per mode
// [R2] first flag: match, output change, pulse start or end per mode
// [R3] enable bit 0 and 1 gate each flag into interrupt
// [R4] enable low resets internal state, outputs default, registers kept
// [R5] reload copies period and parameters at period event, then clears
// [R6] polarity bit one means external reset active low
// [R7] timing bit one stops counter at next pwm clock
// [R8] timing bit zero stops counter at period end
// [R9] polarity bits 7 and 6 make outputs active low
// [R10] push-pull alternates outputs each period, left and right only; code applies it in every mode
// [R11] mode field selects alignment, codes 11x force reset state; code keeps outputs and flags inactive, timer still runs
// [R12] compare: code 101 toggles, 100 sets output high on match
// [R13] software writes configuration only while disabled
// [R14] left and right modes hold output high n clocks
// [R15] center mode holds output high 2n clocks around period event
// [R16] variable mode: high at first match, low at second match
// [R17] compare modes raise match event when timer equals parameter
// [R18] shared load register mirrors reload bit
// [R19] shared enable register mirrors enable bit
// [R20] parameters accessed as separate high and low bytes
// [R21] period event when timer equals period, timer returns to zero
// [R22] combined bit is or of enabled flags
// [R23] software clears flags, hardware never does
// [R24] hardware set beats software clear in same cycle
module psc_top
  import psc_pkg::*;
#(
  parameter int INST_IDX = 0
) (
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  input  wire logic [`PSC_ADDR_W-1:0]   addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [7:0]               rdata_o,
  input  wire logic                     pwm_tick_i,
  input  wire logic [15:0]              period_value_i,
  input  wire logic                     ext_reset_i,
  output logic                          first_param_output_o,
  output logic                          second_param_output_o,
  output logic                          combined_interrupt_bit_o,
  output logic                          period_event_o,
  output logic                          enable_o
);

  logic       [1:0]  slice_interrupt_flags;
  logic       [1:0]  slice_interrupt_enables;
  logic              mod_en;
  logic              reload_request;
  logic              ext_reset_polarity;
  logic              ext_reset_timing;
  logic       [7:0]  slice_configuration;
  psc_word_t         slice_first_parameter;
  psc_word_t         slice_second_parameter;
  psc_word_t         p1_act;
  psc_word_t         p2_act;
  psc_word_t         pr_act;
  psc_word_t         timer;
  logic              ext_meta;
  logic              ext_sync;
  logic              stop_pend;
  logic              stopped;
  logic              pp_phase;
  logic              var_state;
  logic       [1:0]  cmp_state;
  logic       [1:0]  raw_q;
  logic       [1:0]  raw_next;
  logic       [1:0]  hw_evt;
  logic              ext_act;
  logic              run;
  logic              period_evt;
  logic              match1;
  logic              match2;
  logic              first_output_polarity;
  logic              second_output_polarity;
  logic              push_pull_enable;
  psc_mode_t         mode;
  logic              own_ld_mirror;
  logic              own_en_mirror;

  assign first_output_polarity  = slice_configuration[`PSC_BIT_FIRST_OUTPUT_POLARITY];
  assign second_output_polarity = slice_configuration[`PSC_BIT_SECOND_OUTPUT_POLARITY];
  assign push_pull_enable       = slice_configuration[`PSC_BIT_PUSH_PULL_ENABLE];

  // [R11] mode decode
  always_comb begin
    case (slice_configuration[`PSC_MODE_HI:`PSC_MODE_LO])
      `PSC_MODE_LEFT:   mode = PSC_LEFT;
      `PSC_MODE_RIGHT:  mode = PSC_RIGHT;
      `PSC_MODE_CENTER: mode = PSC_CENTER;
      `PSC_MODE_VAR:    mode = PSC_VARIABLE;
      `PSC_MODE_CSET:   mode = PSC_CMP_SET;
      `PSC_MODE_CTOG:   mode = PSC_CMP_TOGGLE;
      default:          mode = PSC_RESERVED;
    endcase
  end

  // pin passes two flops before anything reads it
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= ext_reset_i;
      ext_sync <= ext_meta;
    end
  end

  // [R6] polarity select
  assign ext_act = ext_reset_polarity ? ~ext_sync : ext_sync;

  assign run        = mod_en & ~stopped;
  // [R21] period match
  assign period_evt = run & pwm_tick_i & (timer == pr_act);
  assign match1     = run & pwm_tick_i & (timer == p1_act);
  assign match2     = run & pwm_tick_i & (timer == p2_act);
  assign period_event_o = period_evt;

  // [R21] timer wraps to zero on period event
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer <= `PSC_RST_WORD;
    end else if (!run) begin
      timer <= `PSC_RST_WORD;
    end else if (pwm_tick_i) begin
      timer <= period_evt ? `PSC_RST_WORD : timer + 16'h0001;
    end
  end

  // external reset stop control
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_pend <= 1'b0;
      stopped   <= 1'b0;
    end else if (!mod_en) begin
      stop_pend <= 1'b0;
      stopped   <= 1'b0;
    end else if (!ext_act) begin
      stop_pend <= 1'b0;
      stopped   <= 1'b0;
    // [R7] stop on next pwm clock
    end else if (ext_reset_timing) begin
      if (pwm_tick_i) begin
        stopped <= 1'b1;
      end
    // [R8] finish period first
    end else begin
      stop_pend <= 1'b1;
      if (period_evt) begin
        stopped <= 1'b1;
      end
    end
  end

  // [R5] active buffers; while disabled they track the registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      p1_act <= `PSC_RST_WORD;
      p2_act <= `PSC_RST_WORD;
      pr_act <= `PSC_RST_WORD;
    end else if (!mod_en || (period_evt && reload_request)) begin
      p1_act <= slice_first_parameter;
      p2_act <= slice_second_parameter;
      pr_act <= period_value_i;
    end
  end

  // [R10] push-pull phase flips every period
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pp_phase <= 1'b0;
    end else if (!run) begin
      pp_phase <= 1'b0;
    end else if (period_evt) begin
      pp_phase <= ~pp_phase;
    end
  end

  // [R16] variable aligned state; second match wins a tie
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      var_state <= 1'b0;
    end else if (!run || mode != PSC_VARIABLE) begin
      var_state <= 1'b0;
    end else if (match2) begin
      var_state <= 1'b0;
    end else if (match1) begin
      var_state <= 1'b1;
    end
  end

  // [R12] compare set or toggle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_state <= 2'h0;
    end else if (!run) begin
      cmp_state <= 2'h0;
    end else if (mode == PSC_CMP_SET) begin
      cmp_state <= cmp_state | {match2, match1};
    end else if (mode == PSC_CMP_TOGGLE) begin
      cmp_state <= cmp_state ^ {match2, match1};
    end else begin
      cmp_state <= 2'h0;
    end
  end

  // raw active-high level per output, computed from the timer
  always_comb begin
    logic [16:0] sum1;
    logic [16:0] sum2;
    logic [16:0] pr_w;
    sum1 = {1'b0, timer} + {1'b0, p1_act};
    sum2 = {1'b0, timer} + {1'b0, p2_act};
    pr_w = {1'b0, pr_act};
    raw_next = 2'h0;
    if (run) begin
      case (mode)
        // [R14] pulse at start of period
        PSC_LEFT: begin
          raw_next = {timer < p2_act, timer < p1_act};
        end
        // [R14] pulse at end of period
        PSC_RIGHT: begin
          raw_next = {sum2 > pr_w, sum1 > pr_w};
        end
        // [R15] n before and n after the period event
        PSC_CENTER: begin
          raw_next = {(timer < p2_act) || (sum2 > pr_w), (timer < p1_act) || (sum1 > pr_w)};
        end
        PSC_VARIABLE: begin
          raw_next = {var_state, var_state};
        end
        PSC_CMP_SET,
        PSC_CMP_TOGGLE: begin
          raw_next = cmp_state;
        end
        default: begin
          raw_next = 2'h0;
        end
      endcase
      // [R10] only one output driven per period
      if (push_pull_enable) begin
        raw_next = raw_next & {pp_phase, ~pp_phase};
      end
    end
  end

  // [R4] outputs at inactive level while disabled or stopped
  // [R9] polarity applied last
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      raw_q                 <= 2'h0;
      first_param_output_o  <= 1'b0;
      second_param_output_o <= 1'b0;
    end else begin
      raw_q                 <= raw_next;
      first_param_output_o  <= raw_next[0] ^ first_output_polarity;
      second_param_output_o <= raw_next[1] ^ second_output_polarity;
    end
  end

  // flag events per mode
  always_comb begin
    hw_evt = 2'h0;
    case (mode)
      // [R1] [R2] right aligned: pulse start
      PSC_RIGHT:  hw_evt = raw_next & ~raw_q;
      // [R1] [R2] left aligned: pulse end
      PSC_LEFT:   hw_evt = ~raw_next & raw_q;
      // [R1] [R2] center: any change
      PSC_CENTER: hw_evt = raw_next ^ raw_q;
      // [R17] match in variable and compare modes
      PSC_VARIABLE,
      PSC_CMP_SET,
      PSC_CMP_TOGGLE: hw_evt = {match2, match1};
      default:    hw_evt = 2'h0;
    endcase
    if (!run) begin
      hw_evt = 2'h0;
    end
  end

  // [R24] set wins over a clearing write
  // [R23] only software clears
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slice_interrupt_flags <= 2'h0;
    end else if (wr_i && addr_i == `PSC_OFS_FLAGS) begin
      slice_interrupt_flags <= wdata_i[`PSC_BIT_P2:`PSC_BIT_P1] | hw_evt;
    end else begin
      slice_interrupt_flags <= slice_interrupt_flags | hw_evt;
    end
  end

  // [R3] [R22] enabled flags or'ed, clears when all are cleared
  assign combined_interrupt_bit_o = |(slice_interrupt_flags & slice_interrupt_enables);
  assign enable_o = mod_en;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slice_interrupt_enables <= 2'h0;
    end else if (wr_i && addr_i == `PSC_OFS_ENABLES) begin
      slice_interrupt_enables <= wdata_i[`PSC_BIT_P2:`PSC_BIT_P1];
    end
  end

  // [R19] enable written from control or shared mirror
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mod_en <= 1'b0;
    end else if (wr_i && addr_i == `PSC_OFS_CONTROL) begin
      mod_en <= wdata_i[`PSC_BIT_EN];
    end else if (wr_i && addr_i == `PSC_OFS_EN_MIR) begin
      mod_en <= wdata_i[INST_IDX];
    end
  end

  // [R5] [R18] reload request; a fresh write beats the completion clear
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reload_request <= 1'b0;
    end else if (wr_i && addr_i == `PSC_OFS_CONTROL) begin
      reload_request <= wdata_i[`PSC_BIT_LD];
    end else if (wr_i && addr_i == `PSC_OFS_LOAD_MIR) begin
      reload_request <= wdata_i[INST_IDX];
    end else if (period_evt) begin
      reload_request <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_reset_polarity <= 1'b0;
      ext_reset_timing   <= 1'b0;
    end else if (wr_i && addr_i == `PSC_OFS_CONTROL) begin
      ext_reset_polarity <= wdata_i[`PSC_BIT_EXT_RESET_POLARITY];
      ext_reset_timing   <= wdata_i[`PSC_BIT_EXT_RESET_TIMING];
    end
  end

  // [R13] writes while enabled are taken but unsafe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slice_configuration <= `PSC_RST_BYTE;
    end else if (wr_i && addr_i == `PSC_OFS_CONFIG) begin
      slice_configuration <= wdata_i & `PSC_CFG_MASK;
    end
  end

  // [R20] byte-wide parameter access
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slice_first_parameter  <= `PSC_RST_WORD;
      slice_second_parameter <= `PSC_RST_WORD;
    end else if (wr_i) begin
      if (addr_i == `PSC_OFS_P1_LO) begin
        slice_first_parameter[7:0] <= wdata_i;
      end else if (addr_i == `PSC_OFS_P1_HI) begin
        slice_first_parameter[15:8] <= wdata_i;
      end else if (addr_i == `PSC_OFS_P2_LO) begin
        slice_second_parameter[7:0] <= wdata_i;
      end else if (addr_i == `PSC_OFS_P2_HI) begin
        slice_second_parameter[15:8] <= wdata_i;
      end
    end
  end

  // other instances' mirror bits live elsewhere and read as zero here
  always_comb begin
    own_ld_mirror = reload_request;
    own_en_mirror = mod_en;
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `PSC_RST_BYTE;
    end else if (rd_i) begin
      if (addr_i == `PSC_OFS_FLAGS) begin
        rdata_o <= {6'h00, slice_interrupt_flags};
      end else if (addr_i == `PSC_OFS_ENABLES) begin
        rdata_o <= {6'h00, slice_interrupt_enables};
      end else if (addr_i == `PSC_OFS_CONTROL) begin
        rdata_o <= {mod_en, 4'h0, reload_request, ext_reset_polarity, ext_reset_timing};
      end else if (addr_i == `PSC_OFS_CONFIG) begin
        rdata_o <= slice_configuration;
      end else if (addr_i == `PSC_OFS_P1_LO) begin
        rdata_o <= slice_first_parameter[7:0];
      end else if (addr_i == `PSC_OFS_P1_HI) begin
        rdata_o <= slice_first_parameter[15:8];
      end else if (addr_i == `PSC_OFS_P2_LO) begin
        rdata_o <= slice_second_parameter[7:0];
      end else if (addr_i == `PSC_OFS_P2_HI) begin
        rdata_o <= slice_second_parameter[15:8];
      // [R18] load mirror
      end else if (addr_i == `PSC_OFS_LOAD_MIR) begin
        rdata_o <= 8'(own_ld_mirror) << INST_IDX;
      // [R19] enable mirror
      end else if (addr_i == `PSC_OFS_EN_MIR) begin
        rdata_o <= 8'(own_en_mirror) << INST_IDX;
      end else begin
        rdata_o <= `PSC_RST_BYTE;
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/psc_defines.svh */
/*
  register offsets, field positions, mode codes and reset values of the
  pwm slice compare control block; included by design and dv files.
*/
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_ADDR_W        12
`define PSC_OFS_FLAGS     12'h493
`define PSC_OFS_ENABLES   12'h494
`define PSC_OFS_CONTROL   12'h495
`define PSC_OFS_CONFIG    12'h496
`define PSC_OFS_P1_LO     12'h497
`define PSC_OFS_P1_HI     12'h498
`define PSC_OFS_P2_LO     12'h499
`define PSC_OFS_P2_HI     12'h49a
`define PSC_OFS_LOAD_MIR  12'h49e
`define PSC_OFS_EN_MIR    12'h49f

`define PSC_BIT_P1        0
`define PSC_BIT_P2        1
`define PSC_BIT_EN        7
`define PSC_BIT_LD        2
`define PSC_BIT_EXT_RESET_POLARITY    1
`define PSC_BIT_EXT_RESET_TIMING    0
`define PSC_BIT_SECOND_OUTPUT_POLARITY      7
`define PSC_BIT_FIRST_OUTPUT_POLARITY      6
`define PSC_BIT_PUSH_PULL_ENABLE      3
`define PSC_MODE_HI       2
`define PSC_MODE_LO       0
`define PSC_CFG_MASK      8'hcf

`define PSC_MODE_LEFT     3'h0
`define PSC_MODE_RIGHT    3'h1
`define PSC_MODE_CENTER   3'h2
`define PSC_MODE_VAR      3'h3
`define PSC_MODE_CSET     3'h4
`define PSC_MODE_CTOG     3'h5

`define PSC_RST_BYTE      8'h00
`define PSC_RST_WORD      16'h0000

`endif

/* File: design/psc_pkg.sv */
/*
  types of the pwm slice compare control block.
  assumes psc_defines.svh is on the include path.
*/
`default_nettype none
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_LEFT,
    PSC_RIGHT,
    PSC_CENTER,
    PSC_VARIABLE,
    PSC_CMP_SET,
    PSC_CMP_TOGGLE,
    PSC_RESERVED
  } psc_mode_t;
  typedef logic [15:0] psc_word_t;
endpackage
`default_nettype wire

/* File: dv/psc_top_asserts.sv */
/*
  concurrent checks on the ports of psc_top.
  assumes one clock domain and the register map of psc_defines.svh.
*/
`include "psc_defines.svh"
`default_nettype none
module psc_top_asserts
  import psc_pkg::*;
#(
  parameter int INST_IDX = 0
) (
  input wire logic                   clock_i,
  input wire logic                   nrst_i,
  input wire logic [`PSC_ADDR_W-1:0] addr_i,
  input wire logic [7:0]             wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   pwm_tick_i,
  input wire logic [15:0]            period_value_i,
  input wire logic                   ext_reset_i,
  input wire logic                   first_param_output_o,
  input wire logic                   second_param_output_o,
  input wire logic                   combined_interrupt_bit_o,
  input wire logic                   period_event_o,
  input wire logic                   enable_o
);
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  en_mirror_rd_a: assert property (rd_i && addr_i == `PSC_OFS_EN_MIR |=>
    rdata_o == ({7'h00, $past(enable_o)} << INST_IDX)) else $error("enable mirror read wrong");
  evt_needs_tick_a: assert property (period_event_o |-> pwm_tick_i && enable_o)
    else $error("period event without tick or enable");
  off_outputs_still_a: assert property ((!enable_o && !wr_i) [*3] |->
    $stable(first_param_output_o) && $stable(second_param_output_o)) else $error("outputs move while off");
  irq_masked_a: assert property (wr_i && addr_i == `PSC_OFS_ENABLES && wdata_i[1:0] == 2'b00 |=>
    !combined_interrupt_bit_o) else $error("combined bit set with flags masked");
  cfg_readback_a: assert property (wr_i && addr_i == `PSC_OFS_CONFIG ##2 rd_i && addr_i == `PSC_OFS_CONFIG |=>
    rdata_o == ($past(wdata_i, 3) & 8'hcf)) else $error("configuration read back wrong");
  p1_readback_a: assert property (wr_i && addr_i == `PSC_OFS_P1_LO ##2 rd_i && addr_i == `PSC_OFS_P1_LO |=>
    rdata_o == $past(wdata_i, 3)) else $error("parameter low byte read back wrong");
  ctrl_enable_a: assert property (wr_i && addr_i == `PSC_OFS_CONTROL |=> enable_o == $past(wdata_i[7]))
    else $error("enable does not follow control write");
  mirror_enable_a: assert property (wr_i && addr_i == `PSC_OFS_EN_MIR |=>
    enable_o == $past(wdata_i[INST_IDX])) else $error("enable does not follow mirror write");
endmodule

bind psc_top psc_top_asserts #(.INST_IDX(INST_IDX)) u_asserts (.clock_i(clock_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pwm_tick_i(pwm_tick_i),
  .period_value_i(period_value_i), .ext_reset_i(ext_reset_i), .first_param_output_o(first_param_output_o),
  .second_param_output_o(second_param_output_o), .combined_interrupt_bit_o(combined_interrupt_bit_o),
  .period_event_o(period_event_o), .enable_o(enable_o));
`default_nettype wire

/* File: dv/tb_psc_top.sv */
/*
  bench of psc_top: registers, modes, flags, reload, external reset.
  assumes psc_pkg, psc_top and its checker are compiled first.
*/
`include "psc_defines.svh"
`default_nettype none
module tb_psc_top
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
  logic        pwm_tick_i = 1, ext_reset_i = 0;
  logic [11:0] addr_i = '0;
  logic [7:0]  wdata_i = '0, rdata_o, rv;
  logic [15:0] period_value_i = 16'h0003;
  logic        o1, o2, irq, pev, en;
  int          fails = 0, checks = 0;

  psc_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pwm_tick_i(pwm_tick_i), .period_value_i(period_value_i),
    .ext_reset_i(ext_reset_i), .first_param_output_o(o1), .second_param_output_o(o2),
    .combined_interrupt_bit_o(irq), .period_event_o(pev), .enable_o(en));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(logic [11:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  // window is whole periods, so the count is phase free
  task automatic cnt(int n, output logic [7:0] c1, output logic [7:0] c2, output logic [7:0] ce);
    c1 = 8'h00;
    c2 = 8'h00;
    ce = 8'h00;
    repeat (n) begin
      @(posedge clock_i);
      #1 c1 = c1 + {7'h00, o1};
      c2 = c2 + {7'h00, o2};
      ce = ce + {7'h00, pev};
    end
  endtask

  task automatic cfg(logic [7:0] c, logic [15:0] p1, logic [15:0] p2);
    wr(`PSC_OFS_CONTROL, 8'h00);
    wr(`PSC_OFS_CONFIG, c);
    wr(`PSC_OFS_P1_LO, p1[7:0]);
    wr(`PSC_OFS_P1_HI, p1[15:8]);
    wr(`PSC_OFS_P2_LO, p2[7:0]);
    wr(`PSC_OFS_P2_HI, p2[15:8]);
    wr(`PSC_OFS_FLAGS, 8'h00);
    wr(`PSC_OFS_ENABLES, 8'h03);
    wr(`PSC_OFS_CONTROL, 8'h80);
  endtask

  task automatic regs();
    logic [11:0] a[6] = '{`PSC_OFS_CONFIG, `PSC_OFS_P1_LO, `PSC_OFS_P1_HI, `PSC_OFS_P2_LO, `PSC_OFS_P2_HI, 12'h4a0};
    foreach (a[i]) begin
      rd(a[i]);
      chk(rv, 8'h00);
    end
    wr(`PSC_OFS_P1_LO, 8'h3c);
    rd(`PSC_OFS_P1_LO);
    chk(rv, 8'h3c);
    wr(`PSC_OFS_P2_HI, 8'hc3);
    rd(`PSC_OFS_P2_HI);
    chk(rv, 8'hc3);
    wr(`PSC_OFS_CONFIG, 8'hff);
    rd(`PSC_OFS_CONFIG);
    chk(rv, 8'hcf);
    wr(12'h4a0, 8'hff);
    rd(12'h4a0);
    chk(rv, 8'h00);
    wr(`PSC_OFS_EN_MIR, 8'hff);
    rd(`PSC_OFS_CONTROL);
    chk(rv, 8'h80);
    rd(`PSC_OFS_EN_MIR);
    chk(rv, 8'h01);
    wr(`PSC_OFS_EN_MIR, 8'h00);
    #1 chk({7'h00, en}, 8'h00);
    $display("registers done");
  endtask

  // ef of ff skips the flag check where the flag timing is left open
  task automatic run_mode(logic [7:0] c, logic [15:0] p1, logic [15:0] p2, logic [7:0] e1, logic [7:0] e2,
                          logic [7:0] ef);
    logic [7:0] c1, c2, ce;
    cfg(c, p1, p2);
    repeat (8) @(posedge clock_i);
    cnt(16, c1, c2, ce);
    chk(c1, e1);
    chk(c2, e2);
    chk(ce, 8'd4);
    wr(`PSC_OFS_CONTROL, 8'h00);
    rd(`PSC_OFS_FLAGS);
    if (ef !== 8'hff) begin
      chk(rv & 8'h03, ef);
      chk({7'h00, irq}, {7'h00, ef != 8'h00});
    end
    rd(`PSC_OFS_P1_LO);
    chk(rv, p1[7:0]);
    $display("mode %h done", c);
  endtask

  task automatic irq_case();
    wr(`PSC_OFS_ENABLES, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    wr(`PSC_OFS_ENABLES, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    wr(`PSC_OFS_ENABLES, 8'h02);
    wr(`PSC_OFS_FLAGS, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    rd(`PSC_OFS_FLAGS);
    chk(rv & 8'h03, 8'h01);
    $display("interrupt done");
  endtask

  // clearing write lands on the first timer match with p1
  task automatic set_wins();
    cfg(8'h04, 16'd1, 16'd2);
    wr(`PSC_OFS_FLAGS, 8'h00);
    rd(`PSC_OFS_FLAGS);
    chk(rv & 8'h01, 8'h01);
    $display("set wins done");
  endtask

  task automatic reload();
    logic [7:0] c1, c2, ce;
    cfg(8'h00, 16'd1, 16'd2);
    wr(`PSC_OFS_P1_LO, 8'h02);
    repeat (8) @(posedge clock_i);
    cnt(16, c1, c2, ce);
    chk(c1, 8'd4);
    @(posedge clock_i);
    pwm_tick_i <= 1'b0;
    wr(`PSC_OFS_LOAD_MIR, 8'h01);
    rd(`PSC_OFS_CONTROL);
    chk(rv, 8'h84);
    rd(`PSC_OFS_LOAD_MIR);
    chk(rv, 8'h01);
    @(posedge clock_i);
    pwm_tick_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(`PSC_OFS_LOAD_MIR);
    chk(rv, 8'h00);
    cnt(16, c1, c2, ce);
    chk(c1, 8'd8);
    $display("reload done");
  endtask

  // two sync flops plus a whole period fit in the settle wait
  task automatic ext(logic [7:0] c, logic l, logic [7:0] e);
    logic [7:0] c1, c2, ce;
    wr(`PSC_OFS_CONTROL, c);
    ext_reset_i <= l;
    repeat (10) @(posedge clock_i);
    cnt(8, c1, c2, ce);
    chk(ce, e);
    // p1 of two in a four-clock period
    chk(c1, e + e);
    $display("external reset %h %b done", c, l);
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200us;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    regs();
    run_mode(8'h00, 16'd1, 16'd2, 8'd4, 8'd8, 8'h03);
    irq_case();
    set_wins();
    run_mode(8'h01, 16'd2, 16'd1, 8'd8, 8'd4, 8'h03);
    run_mode(8'h02, 16'd1, 16'd0, 8'd8, 8'd0, 8'h01);
    run_mode(8'h03, 16'd1, 16'd3, 8'd8, 8'd8, 8'h03);
    run_mode(8'h04, 16'd1, 16'd2, 8'd16, 8'd16, 8'h03);
    run_mode(8'h05, 16'd1, 16'd2, 8'd8, 8'd8, 8'h03);
    run_mode(8'h06, 16'd1, 16'd2, 8'd0, 8'd0, 8'h00);
    run_mode(8'h07, 16'd1, 16'd2, 8'd0, 8'd0, 8'h00);
    run_mode(8'hc0, 16'd1, 16'd2, 8'd12, 8'd8, 8'h03);
    run_mode(8'h08, 16'd2, 16'd2, 8'd4, 8'd4, 8'hff);
    reload();
    ext(8'h81, 1'b1, 8'd0);
    ext(8'h81, 1'b0, 8'd2);
    ext(8'h80, 1'b1, 8'd0);
    ext(8'h82, 1'b1, 8'd2);
    ext(8'h82, 1'b0, 8'd0);
    give_verdict();
  end
endmodule
`default_nettype wire
